// ==== src/atcsr_pkg.sv ====
// Package for the terminal configuration and status register bank.
// Assumes one 40 MHz clock and an SPI front end outside this block.
package atcsr_pkg;

   // ----------------------------------------------------------------
   // Instruction codes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_SET_DIVIDER = 8'h07;
   localparam logic [7:0] OP_READ_STATUS = 8'h0a;
   localparam logic [7:0] OP_READ_CONFIG = 8'h0b;
   localparam logic [7:0] OP_WRITE_CONFIG = 8'h10;
   localparam logic [7:0] OP_TX_START     = 8'h12;

   // ----------------------------------------------------------------
   // Configuration word fields
   // ----------------------------------------------------------------
   localparam int CFG_RX_RATE      = 0;
   localparam int CFG_CLK_SRC      = 1;
   localparam int CFG_LABEL_FILT   = 2;
   localparam int CFG_TX_PAR_EN    = 3;
   localparam int CFG_RX_PAR_CHK   = 4;
   localparam int CFG_LOOPBACK_N   = 5;
   localparam int CFG_DEC_EN       = 6;
   localparam int CFG_DEC_B10      = 7;
   localparam int CFG_DEC_B9       = 8;
   localparam int CFG_TX_PAR_POL   = 9;
   localparam int CFG_TX_RATE      = 10;
   localparam int CFG_LABEL_ORDER  = 11;
   localparam int CFG_DRV_DIS      = 12;
   localparam int CFG_TX_AUTO      = 13;
   localparam int CFG_TX_FLAG_SEL  = 14;
   localparam int CFG_RX_FLAG_SEL  = 15;
   localparam logic [15:0] CFG_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // Status word fields
   // ----------------------------------------------------------------
   localparam int ST_RX_EMPTY = 0;
   localparam int ST_RX_HALF  = 1;
   localparam int ST_RX_FULL  = 2;
   localparam int ST_TX_EMPTY = 3;
   localparam int ST_TX_HALF  = 4;
   localparam int ST_TX_FULL  = 5;
   localparam logic [7:0] ST_RESET = 8'h09;

   // ----------------------------------------------------------------
   // Rates and divider
   // ----------------------------------------------------------------
   localparam int FIFO_DEPTH     = 32;
   localparam int FIFO_HALF      = 16;
   localparam int HI_RATE_DIV    = 10;
   localparam int LO_RATE_DIV    = 80;
   localparam logic [3:0] DIV_RESET = 4'h1;

endpackage : atcsr_pkg

// ==== src/atcsr_rate_gen.sv ====
// Rate tick generator: divides the arinc clock tick by 10 or 80.
// Assumes clkTick is a one-cycle pulse on ref_clk.
`timescale 1ns/1ps
module atcsr_rate_gen
   import atcsr_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rstn,
   input  wire logic clkTick,
   input  wire logic lowSpeed,
   output logic      rateTick
);
   logic [6:0] cnt_q;
   logic [6:0] cnt_d;
   wire  [6:0] lastCount = lowSpeed ? 7'(LO_RATE_DIV - 1)
                                    : 7'(HI_RATE_DIV - 1);
   wire        wrap      = clkTick && (cnt_q >= lastCount);

   assign cnt_d = !clkTick ? cnt_q : (wrap ? 7'h00 : cnt_q + 7'h01);

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt_q    <= 7'h00;
         rateTick <= 1'b0;
      end
      else
      begin
         cnt_q    <= cnt_d;
         rateTick <= wrap;
      end
   end
endmodule : atcsr_rate_gen

// ==== src/atcsr_regs.sv ====
// Configuration and status register bank of the serial terminal.
// Assumes a decoded SPI front end: opcode strobes with parallel data,
// and occupancy counts from the FIFOs, all on ref_clk.
`timescale 1ns/1ps

// Operation
// [RULE1] Write instruction loads sixteen-bit configuration
// [RULE2] Read instruction returns configuration word
// [RULE3] Bit 0: receive rate clk/10 or /80
// [RULE4] Bit 1: direct or divided arinc clock
// [RULE5] Bit 2 label filter; bit 6 decoder
// [RULE6] Bit 3: bit 32 data or parity
// [RULE7] Bit 4 enables receive odd parity check
// [RULE8] Bit 5 clear loops transmitter into receiver
// [RULE9] Decoder compares bits 10,9 to bits 7,8
// [RULE10] Bit 9: odd or even transmit parity
// [RULE11] Bit 10: transmit rate and slope
// [RULE12] Bit 11: label bit order on transfers
// [RULE13] Bit 12 disables line driver, null
// [RULE14] Bit 13: start instruction or auto send
// [RULE15] Flag pins select empty or full
// [RULE16] Status read gives eight bits, 6-7 zero
// [RULE17] Status bit 0: receive fifo empty
// [RULE18] Status bit 1: receive holds sixteen plus
// [RULE19] Status bit 2: receive fifo full
// [RULE20] Status bit 3: transmit fifo empty
// [RULE21] Status bits 4,5: transmit half, full
// [RULE22] Empty receive read returns zeros
// [RULE23] Divider only 1,2,4,8,10; else stopped
// [RULE24] Status follows occupancy every cycle
module atcsr_regs
   import atcsr_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH,
   parameter int HALF  = FIFO_HALF,
   parameter int CW    = $clog2(DEPTH + 1)
)
(
   input  wire logic          ref_clk,
   input  wire logic          rstn,
   input  wire logic          opStrobe,
   input  wire logic [7:0]    opCode,
   input  wire logic [15:0]   opData,
   input  wire logic          rxWordRead,
   input  wire logic [31:0]   rxFifoWord,
   input  wire logic [CW-1:0] rxCount,
   input  wire logic [CW-1:0] txCount,
   input  wire logic          rxWordDone,
   input  wire logic [31:0]   rxWord,
   input  wire logic          rxLabelHit,
   output logic [15:0]        readData_q,
   output logic               readValid_q,
   output logic [31:0]        rxReadWord_q,
   output logic [15:0]        configWord_q,
   output logic               rxRateTick_q,
   output logic               txRateTick_q,
   output logic               arincTick_q,
   output logic               rxLoad_q,
   output logic               rxParityErr_q,
   output logic               txParityEnable_q,
   output logic               txParityEven_q,
   output logic               lineDriverDisable_q,
   output logic               loopbackEnable_q,
   output logic               labelReverse_q,
   output logic               txGo_q,
   output logic               txSlowSlope_q,
   output logic               txFifoFlagPin_q,
   output logic               rxFifoFlagPin_q,
   output logic [7:0]         fifoStatusWord_q
);

   // ----------------------------------------------------------------
   // Instruction decode
   // ----------------------------------------------------------------
   wire writeCfg   = opStrobe && (opCode == OP_WRITE_CONFIG);
   wire readCfg    = opStrobe && (opCode == OP_READ_CONFIG);
   wire readStat   = opStrobe && (opCode == OP_READ_STATUS);
   wire setDiv     = opStrobe && (opCode == OP_SET_DIVIDER);
   wire txStartCmd = opStrobe && (opCode == OP_TX_START);

   // ----------------------------------------------------------------
   // Configuration word
   // ----------------------------------------------------------------
   logic [15:0] cfg_d;
   assign cfg_d = writeCfg ? opData : configWord_q; // see [RULE1]

   wire rxLowSpeed = configWord_q[CFG_RX_RATE];  // see [RULE3]
   wire txLowSpeed = configWord_q[CFG_TX_RATE];  // see [RULE11]
   wire useDivided = configWord_q[CFG_CLK_SRC];  // see [RULE4]

   // ----------------------------------------------------------------
   // Status word, rebuilt from the counts every cycle
   // ----------------------------------------------------------------
   wire rxEmpty = (rxCount == CW'(0));               // see [RULE17]
   wire rxHalf  = (rxCount >= CW'(HALF));            // see [RULE18]
   wire rxFull  = (rxCount >= CW'(DEPTH));           // see [RULE19]
   wire txEmpty = (txCount == CW'(0));               // see [RULE20]
   wire txHalf  = (txCount >= CW'(HALF));            // see [RULE21]
   wire txFull  = (txCount >= CW'(DEPTH));           // see [RULE21]
   wire [7:0] stat_d = {2'b00, txFull, txHalf, txEmpty,
                        rxFull, rxHalf, rxEmpty};     // see [RULE16]
   wire txFlag_d = configWord_q[CFG_TX_FLAG_SEL] ? txFull : txEmpty;
   wire rxFlag_d = configWord_q[CFG_RX_FLAG_SEL] ? rxFull : rxEmpty;

   // ----------------------------------------------------------------
   // Clock divider for the arinc clock
   // ----------------------------------------------------------------
   logic [3:0] div_q;
   logic [3:0] divCnt_q;
   logic [3:0] divCnt_d;
   // Nibble only: ratios other than 1, 2, 4, 8 and 10 are meaningless and stop the clock
   wire divLegal = (div_q == 4'h1) || (div_q == 4'h2) ||
                   (div_q == 4'h4) || (div_q == 4'h8) ||
                   (div_q == 4'ha);                   // see [RULE23]
   wire divWrap  = divLegal && (divCnt_q >= div_q - 4'h1);
   assign divCnt_d = !divLegal ? 4'h0 :
                     (divWrap ? 4'h0 : divCnt_q + 4'h1);
   wire arincTick_d = useDivided ? divWrap : 1'b1;    // see [RULE4]

   logic rxTick;
   logic txTick;
   atcsr_rate_gen u_rx_rate
   (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .clkTick  (arincTick_q),
      .lowSpeed (rxLowSpeed),
      .rateTick (rxTick)
   );
   atcsr_rate_gen u_tx_rate
   (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .clkTick  (arincTick_q),
      .lowSpeed (txLowSpeed),
      .rateTick (txTick)
   );

   // ----------------------------------------------------------------
   // Receive word acceptance
   // ----------------------------------------------------------------
   wire labelOk  = !configWord_q[CFG_LABEL_FILT] || rxLabelHit; // see [RULE5]
   wire decOk    = !configWord_q[CFG_DEC_EN] ||
                   ((rxWord[9] == configWord_q[CFG_DEC_B10]) &&
                    (rxWord[8] == configWord_q[CFG_DEC_B9])); // see [RULE9]
   // Set means the received word did not carry odd parity
   wire parErr   = configWord_q[CFG_RX_PAR_CHK] && !(^rxWord); // see [RULE7]

   // ----------------------------------------------------------------
   // Read answers
   // ----------------------------------------------------------------
   wire [15:0] rd_d = readCfg  ? configWord_q :            // see [RULE2]
                      readStat ? {8'h00, fifoStatusWord_q} : 16'h0000;
   // Empty fifo yields zeros rather than stale data
   wire [31:0] rxRd_d = rxEmpty ? 32'h0000_0000 : rxFifoWord; // see [RULE22]

   // Transmit go: latched by instruction, or auto while data waits
   wire txGo_d = configWord_q[CFG_TX_AUTO] ? !txEmpty :      // see [RULE14]
                 (txEmpty ? 1'b0 : (txGo_q || txStartCmd));

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         configWord_q     <= CFG_RESET;
         fifoStatusWord_q <= ST_RESET;
         div_q            <= DIV_RESET;
         divCnt_q         <= 4'h0;
         arincTick_q      <= 1'b0;
         readData_q       <= 16'h0000;
         readValid_q      <= 1'b0;
         rxReadWord_q     <= 32'h0000_0000;
         txGo_q           <= 1'b0;
      end
      else
      begin
         configWord_q     <= cfg_d;
         fifoStatusWord_q <= stat_d;                // see [RULE24]
         div_q            <= setDiv ? opData[3:0] : div_q;
         divCnt_q         <= divCnt_d;
         arincTick_q      <= arincTick_d;
         readData_q       <= rd_d;
         readValid_q      <= readCfg || readStat;
         rxReadWord_q     <= rxWordRead ? rxRd_d : rxReadWord_q;
         txGo_q           <= txGo_d;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rxRateTick_q        <= 1'b0;
         txRateTick_q        <= 1'b0;
         rxLoad_q            <= 1'b0;
         rxParityErr_q       <= 1'b0;
         txParityEnable_q    <= 1'b0;
         txParityEven_q      <= 1'b0;
         lineDriverDisable_q <= 1'b0;
         loopbackEnable_q    <= 1'b1;
         labelReverse_q      <= 1'b1;
         txSlowSlope_q       <= 1'b0;
         txFifoFlagPin_q     <= 1'b1;
         rxFifoFlagPin_q     <= 1'b1;
      end
      else
      begin
         rxRateTick_q        <= rxTick;
         txRateTick_q        <= txTick;
         rxLoad_q            <= rxWordDone && labelOk && decOk; // see [RULE5]
         rxParityErr_q       <= parErr;
         txParityEnable_q    <= configWord_q[CFG_TX_PAR_EN];  // see [RULE6]
         txParityEven_q      <= configWord_q[CFG_TX_PAR_POL]; // see [RULE10]
         lineDriverDisable_q <= configWord_q[CFG_DRV_DIS];    // see [RULE13]
         loopbackEnable_q    <= !configWord_q[CFG_LOOPBACK_N]; // see [RULE8]
         labelReverse_q      <= !configWord_q[CFG_LABEL_ORDER]; // see [RULE12]
         txSlowSlope_q       <= txLowSpeed;                   // see [RULE11]
         txFifoFlagPin_q     <= txFlag_d;                     // see [RULE15]
         rxFifoFlagPin_q     <= rxFlag_d;                     // see [RULE15]
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_cfg_write;
      @(posedge ref_clk) disable iff (!rstn)
      writeCfg |=> (configWord_q == $past(opData));
   endproperty
   a_cfg_write: assert property (p_cfg_write) // see [RULE1]
      else $error("config word not loaded");

   property p_cfg_read;
      @(posedge ref_clk) disable iff (!rstn)
      readCfg |=> readValid_q && (readData_q == $past(configWord_q));
   endproperty
   a_cfg_read: assert property (p_cfg_read) // see [RULE2]
      else $error("config read wrong");

   property p_stat_read;
      @(posedge ref_clk) disable iff (!rstn)
      readStat |=> readValid_q && (readData_q[15:6] == 10'h000) &&
                   (readData_q[5:0] == $past(fifoStatusWord_q[5:0]));
   endproperty
   a_stat_read: assert property (p_stat_read) // see [RULE16]
      else $error("status upper bits not zero");

   property p_rx_empty;
      @(posedge ref_clk) disable iff (!rstn)
      (rxCount == CW'(0)) |=> fifoStatusWord_q[ST_RX_EMPTY];
   endproperty
   a_rx_empty: assert property (p_rx_empty) // see [RULE17]
      else $error("rx empty flag wrong");

   property p_rx_half;
      @(posedge ref_clk) disable iff (!rstn)
      1'b1 |=> fifoStatusWord_q[ST_RX_HALF] == ($past(rxCount) >= CW'(HALF));
   endproperty
   a_rx_half: assert property (p_rx_half) // see [RULE18]
      else $error("rx half flag wrong");

   property p_tx_full;
      @(posedge ref_clk) disable iff (!rstn)
      1'b1 |=> fifoStatusWord_q[ST_TX_FULL] == ($past(txCount) >= CW'(DEPTH));
   endproperty
   a_tx_full: assert property (p_tx_full) // see [RULE21]
      else $error("tx full flag wrong");

   property p_flag_pin;
      @(posedge ref_clk) disable iff (!rstn)
      configWord_q[CFG_RX_FLAG_SEL] && rxFull |=> rxFifoFlagPin_q;
   endproperty
   a_flag_pin: assert property (p_flag_pin) // see [RULE15]
      else $error("rx flag pin wrong");

   property p_div_stop;
      @(posedge ref_clk) disable iff (!rstn)
      (useDivided && !divLegal) [*2] |=> !arincTick_q;
   endproperty
   a_div_stop: assert property (p_div_stop) // see [RULE23]
      else $error("illegal divider still ticks");

   property p_empty_read;
      @(posedge ref_clk) disable iff (!rstn)
      rxWordRead && rxEmpty |=> (rxReadWord_q == 32'h0000_0000);
   endproperty
   a_empty_read: assert property (p_empty_read) // see [RULE22]
      else $error("empty read not zero");

endmodule : atcsr_regs

// ==== sim/atcsr_host_model.sv ====
// Host side of the decoded instruction port: issues one instruction
// per call. Assumes the testbench calls send between clock edges.
`timescale 1ns/1ps
module atcsr_host_model
   import atcsr_pkg::*;
(
   input  wire logic   ref_clk,
   output logic        opStrobe,
   output logic [7:0]  opCode,
   output logic [15:0] opData
);
   initial
   begin
      opStrobe = 1'b0;
      opCode   = 8'h00;
      opData   = 16'h0000;
   end

   // Idle bus is scrambled so a stale word is never mistaken for a new one
   task automatic send(input logic [7:0] code, input logic [15:0] data);
      @(posedge ref_clk);
      opStrobe <= 1'b1;
      opCode   <= code;
      opData   <= data;
      @(posedge ref_clk);
      opStrobe <= 1'b0;
      opCode   <= ~code;
      opData   <= ~data;
   endtask : send
endmodule : atcsr_host_model

// ==== sim/tb_atcsr_regs.sv ====
// Self-checking bench for the configuration and status register bank.
// Assumes the default fifo depth of 32 and the direct reference clock.
`timescale 1ns/1ps
module tb_atcsr_regs;
   import atcsr_pkg::*;
   typedef struct packed {logic [5:0] rx; logic [5:0] tx; logic [7:0] st;}
      atcsr_row_type;
   typedef struct packed {logic [15:0] cfg; logic [31:0] w; logic hit;
      logic ld; logic pe;} atcsr_rxrow_type;
   logic        ref_clk, rstn, rxWordRead, rxWordDone, rxLabelHit;
   logic [31:0] rxFifoWord, rxWord, rxReadWord_q;
   logic [5:0]  rxCount, txCount;
   wire logic        opStrobe;
   wire logic [7:0]  opCode;
   wire logic [15:0] opData;
   logic [15:0] readData_q, configWord_q, w;
   logic [7:0]  fifoStatusWord_q;
   logic readValid_q, rxRateTick_q, txRateTick_q, arincTick_q, rxLoad_q;
   logic rxParityErr_q, txParityEnable_q, txParityEven_q, txGo_q;
   logic lineDriverDisable_q, loopbackEnable_q, labelReverse_q;
   logic txSlowSlope_q, txFifoFlagPin_q, rxFifoFlagPin_q;
   int err_total, tests_run, cycles, n;
   atcsr_row_type rows [8] = '{'{6'd0, 6'd0, 8'h09}, '{6'd1, 6'd1, 8'h00},
      '{6'd15, 6'd15, 8'h00}, '{6'd16, 6'd16, 8'h12},
      '{6'd31, 6'd31, 8'h12}, '{6'd32, 6'd32, 8'h36},
      '{6'd0, 6'd32, 8'h31}, '{6'd32, 6'd0, 8'h0e}};
   atcsr_rxrow_type rxRows [8] = '{'{16'h0000, 32'h0, 1'b0, 1'b1, 1'b0},
      '{16'h0004, 32'h0, 1'b0, 1'b0, 1'b0},
      '{16'h0004, 32'h0, 1'b1, 1'b1, 1'b0},
      '{16'h00c0, 32'h200, 1'b0, 1'b1, 1'b0},
      '{16'h00c0, 32'h100, 1'b0, 1'b0, 1'b0},
      '{16'h0144, 32'h100, 1'b0, 1'b0, 1'b0},
      '{16'h0010, 32'h3, 1'b1, 1'b1, 1'b1},
      '{16'h0150, 32'h1, 1'b1, 1'b0, 1'b0}};

   atcsr_regs u_atcsr_regs (.ref_clk(ref_clk), .rstn(rstn),
      .opStrobe(opStrobe), .opCode(opCode), .opData(opData),
      .rxWordRead(rxWordRead), .rxFifoWord(rxFifoWord), .rxCount(rxCount),
      .txCount(txCount), .rxWordDone(rxWordDone), .rxWord(rxWord),
      .rxLabelHit(rxLabelHit), .readData_q(readData_q),
      .readValid_q(readValid_q), .rxReadWord_q(rxReadWord_q),
      .configWord_q(configWord_q), .rxRateTick_q(rxRateTick_q),
      .txRateTick_q(txRateTick_q), .arincTick_q(arincTick_q),
      .rxLoad_q(rxLoad_q), .rxParityErr_q(rxParityErr_q),
      .txParityEnable_q(txParityEnable_q), .txParityEven_q(txParityEven_q),
      .lineDriverDisable_q(lineDriverDisable_q),
      .loopbackEnable_q(loopbackEnable_q), .labelReverse_q(labelReverse_q),
      .txGo_q(txGo_q), .txSlowSlope_q(txSlowSlope_q),
      .txFifoFlagPin_q(txFifoFlagPin_q), .rxFifoFlagPin_q(rxFifoFlagPin_q),
      .fifoStatusWord_q(fifoStatusWord_q));
   atcsr_host_model u_atcsr_host_model (.ref_clk(ref_clk),
      .opStrobe(opStrobe), .opCode(opCode), .opData(opData));

   task automatic chk(input logic [31:0] got, exp, input string what);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done

   task automatic op(input logic [7:0] c, input logic [15:0] d);
      u_atcsr_host_model.send(c, d);
      #1;
   endtask : op

   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask : tick

   // First two passes only align to the new rate; the third is measured
   task automatic gap(input bit tx, output int g);
      repeat (3)
      begin
         g = 0;
         do
         begin
            tick(1);
            g++;
         end while ((tx ? txRateTick_q : rxRateTick_q) !== 1'b1 && g < 400);
      end
   endtask : gap

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         err_total++;
         test_done();
      end
   end

   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   initial
   begin
      {rstn, rxWordRead, rxWordDone, rxLabelHit, rxCount, txCount} = '0;
      {rxFifoWord, rxWord} = '0;
      repeat (4) @(posedge ref_clk);
      rstn <= 1'b1;
      #1;
      chk(configWord_q, CFG_RESET, "reset cfg");
      chk(fifoStatusWord_q, 8'h09, "reset status");
      chk({txFifoFlagPin_q, rxFifoFlagPin_q, loopbackEnable_q,
         labelReverse_q}, 4'hf, "reset pins");
      // ----------------------------------------------------------------
      // Occupancy table under both flag pin meanings
      // ----------------------------------------------------------------
      for (int f = 0; f < 2; f++)
      begin
         op(OP_WRITE_CONFIG, f ? 16'hc000 : 16'h0000);
         foreach (rows[i])
         begin
            @(posedge ref_clk);
            rxCount <= rows[i].rx;
            txCount <= rows[i].tx;
            tick(2);
            chk(fifoStatusWord_q, rows[i].st, "status");
            chk({txFifoFlagPin_q, rxFifoFlagPin_q}, f ? {rows[i].st[5],
               rows[i].st[2]} : {rows[i].st[3], rows[i].st[0]}, "flags");
            op(OP_READ_STATUS, 16'h0000);
            chk({readValid_q, readData_q}, {9'h100, rows[i].st}, "rd st");
         end
      end
      // ----------------------------------------------------------------
      // Each configuration bit: store, read back, decode
      // ----------------------------------------------------------------
      for (int i = 0; i < 16; i++)
      begin
         w = 16'h0001 << i;
         op(OP_WRITE_CONFIG, w);
         chk(configWord_q, w, "cfg");
         op(OP_READ_CONFIG, 16'h0000);
         chk(readData_q, w, "rd cfg");
         chk({txParityEnable_q, txParityEven_q, txSlowSlope_q, labelReverse_q,
            lineDriverDisable_q, loopbackEnable_q}, {w[3], w[9], w[10],
            ~w[11], w[12], ~w[5]}, "decode");
      end
      op(8'h55, 16'hffff);
      chk({readData_q, configWord_q}, {16'h0000, 16'h8000}, "refused");
      // ----------------------------------------------------------------
      // Filter and parity
      // ----------------------------------------------------------------
      foreach (rxRows[i])
      begin
         op(OP_WRITE_CONFIG, rxRows[i].cfg);
         @(posedge ref_clk);
         rxWordDone <= 1'b1;
         rxWord     <= rxRows[i].w;
         rxLabelHit <= rxRows[i].hit;
         @(posedge ref_clk);
         rxWordDone <= 1'b0;
         rxWord     <= ~rxRows[i].w;
         rxLabelHit <= ~rxRows[i].hit;
         #1;
         n = rxLoad_q;
         repeat (2)
         begin
            tick(1);
            n += rxLoad_q;
         end
         chk(n, rxRows[i].ld, "load");
         chk(rxParityErr_q, rxRows[i].pe, "parity");
      end
      // ----------------------------------------------------------------
      // Bit rates and clock divider
      // ----------------------------------------------------------------
      op(OP_WRITE_CONFIG, 16'h0000);
      n = 0;
      repeat (20)
      begin
         tick(1);
         n += arincTick_q;
      end
      chk(n, 20, "direct clk");
      gap(0, n);
      chk(n, HI_RATE_DIV, "rx hi");
      gap(1, n);
      chk(n, HI_RATE_DIV, "tx hi");
      // One rate bit at a time, so swapped selects cannot hide
      op(OP_WRITE_CONFIG, 16'h0001);
      gap(0, n);
      chk(n, LO_RATE_DIV, "rx lo");
      gap(1, n);
      chk(n, HI_RATE_DIV, "tx stays hi");
      op(OP_WRITE_CONFIG, 16'h0400);
      gap(1, n);
      chk(n, LO_RATE_DIV, "tx lo");
      gap(0, n);
      chk(n, HI_RATE_DIV, "rx back hi");
      op(OP_SET_DIVIDER, 16'h0002);
      op(OP_WRITE_CONFIG, 16'h0002);
      gap(0, n);
      chk(n, 2 * HI_RATE_DIV, "div 2");
      op(OP_SET_DIVIDER, 16'h0003);
      tick(4);
      n = 0;
      repeat (40)
      begin
         tick(1);
         n += arincTick_q;
      end
      chk(n, 0, "div 3");
      op(OP_SET_DIVIDER, 16'h000a);
      gap(0, n);
      chk(n, 10 * HI_RATE_DIV, "div a");
      // ----------------------------------------------------------------
      // Receive word read, empty and not empty
      // ----------------------------------------------------------------
      for (int k = 0; k < 2; k++)
      begin
         @(posedge ref_clk);
         rxCount    <= k;
         rxFifoWord <= 32'h1234abcd;
         tick(2);
         chk(fifoStatusWord_q[ST_RX_EMPTY], k == 0, "poll");
         @(posedge ref_clk);
         rxWordRead <= 1'b1;
         @(posedge ref_clk);
         rxWordRead <= 1'b0;
         rxFifoWord <= 32'hedcb5432;
         #1;
         chk(rxReadWord_q, k ? 32'h1234abcd : 32'h0, "rx read");
      end
      // ----------------------------------------------------------------
      // Transmit start modes
      // ----------------------------------------------------------------
      op(OP_WRITE_CONFIG, 16'h0000);
      @(posedge ref_clk);
      txCount <= 6'd5;
      tick(3);
      chk(txGo_q, 1'b0, "no start");
      op(OP_TX_START, 16'h0000);
      tick(1);
      chk(txGo_q, 1'b1, "start");
      @(posedge ref_clk);
      txCount <= 6'd0;
      tick(3);
      chk(txGo_q, 1'b0, "drained");
      op(OP_WRITE_CONFIG, 16'h2000);
      @(posedge ref_clk);
      txCount <= 6'd3;
      tick(3);
      chk(txGo_q, 1'b1, "auto");
      // ----------------------------------------------------------------
      // Reset in mid-run, with both fifos holding words
      // ----------------------------------------------------------------
      @(posedge ref_clk);
      rstn <= 1'b0;
      tick(1);
      chk({configWord_q, txGo_q, fifoStatusWord_q},
         {CFG_RESET, 1'b0, 8'h09}, "mid reset");
      @(posedge ref_clk);
      rstn <= 1'b1;
      tick(2);
      chk({txGo_q, fifoStatusWord_q}, 9'h000, "after reset");
      test_done();
   end
endmodule : tb_atcsr_regs
